// ==== inc/asp_defines.svh ====
`ifndef ASP_DEFINES_SVH
`define ASP_DEFINES_SVH

// ==========================================================
// register byte offsets
`define ASP_OFF_CTRL 8'h00
`define ASP_OFF_DATA 8'h04
`define ASP_OFF_TCTRL 8'h08
`define ASP_OFF_RELOAD 8'h0C
`define ASP_OFF_IRQ_STAT 8'h10
`define ASP_OFF_IRQ_MASK 8'h14

// ==========================================================
// serial_control_reg fields
`define ASP_CTRL_MODE9 7
`define ASP_CTRL_MCE 5
`define ASP_CTRL_RXEN 4
`define ASP_CTRL_TXN9 3
`define ASP_CTRL_RXN9 2
`define ASP_CTRL_TXDONE 1
`define ASP_CTRL_RXDONE 0
`define ASP_CTRL_RESET 8'h40

// ==========================================================
// timer control fields
`define ASP_TCTRL_RUN 0
`define ASP_TCTRL_SEL_LSB 1
`define ASP_TCTRL_SEL_MSB 3

// ==========================================================
// interrupt status and mask bits
`define ASP_IRQ_TX 0
`define ASP_IRQ_RX 1

// ==========================================================
// baud clock prescaler, timer counter and frame bit counts
`define ASP_PRE_LAST 6'h2F
`define ASP_PRE_DIV4_MASK 6'h03
`define ASP_PRE_DIV12 6'h0C
`define ASP_XOSC_LAST 3'h7
`define ASP_CNT_TOP 8'hFF
`define ASP_BITS_8 4'h7
`define ASP_BITS_9 4'h8

`endif

// ==== inc/asp_pkg.sv ====
package asp_pkg;

    // baud timer clock sources
    typedef enum logic [2:0] {
        ASP_CLK_SYS,
        ASP_CLK_DIV4,
        ASP_CLK_DIV12,
        ASP_CLK_DIV48,
        ASP_CLK_XOSC8,
        ASP_CLK_EXT
    } asp_clk_sel_t;

    typedef enum logic [2:0] {
        TX_IDLE,
        TX_START,
        TX_DATA,
        TX_NINTH,
        TX_STOP
    } asp_tx_state_t;

    typedef enum logic [1:0] {
        RX_IDLE,
        RX_START,
        RX_DATA,
        RX_STOP
    } asp_rx_state_t;

endpackage

// ==== rtl/asp_baud_timer.sv ====
`timescale 1ns/1ps
`include "asp_defines.svh"

module asp_baud_timer (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic run, // timer enable
    input wire asp_pkg::asp_clk_sel_t sel, // timer clock source
    input wire logic [7:0] reload, // auto-reload value
    input wire logic ext_osc_clk, // external oscillator, sampled
    input wire logic timer_ext_in, // external timer input, sampled
    input wire logic rx_restart, // start bit seen, reload rx copy
    output logic tx_bit_tick, // one pulse per transmit bit
    output logic rx_half_tick // rx copy overflow, half a bit
);
    import asp_pkg::*;

    logic [5:0] pre;
    logic [2:0] xosc_cnt;
    logic xosc_prev;
    logic ext_prev;
    logic tick;
    logic [7:0] tx_cnt;
    logic [7:0] rx_cnt;
    logic tx_half;
    logic tx_ovf;

    // ==========================================================
    // clock source selection
    function automatic logic div12_hit(input logic [5:0] p);
        div12_hit = (p == `ASP_PRE_DIV12 - 6'h01) || (p == 6'h17) ||
                    (p == 6'h23) || (p == `ASP_PRE_LAST);
    endfunction

    // one free prescaler serves the /4, /12 and /48 taps
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre <= 6'h00;
        end else begin
            pre <= (pre == `ASP_PRE_LAST) ? 6'h00 : pre + 6'h01;
        end
    end

    // inputs are already synchronous, so plain edge detection suffices
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            xosc_prev <= 1'b0;
            ext_prev <= 1'b0;
            xosc_cnt <= 3'h0;
        end else begin
            xosc_prev <= ext_osc_clk;
            ext_prev <= timer_ext_in;
            if (ext_osc_clk && !xosc_prev) begin
                xosc_cnt <= xosc_cnt + 3'h1;
            end
        end
    end

    always_comb begin
        case (sel)
            ASP_CLK_SYS: tick = 1'b1;
            ASP_CLK_DIV4: tick = (pre & `ASP_PRE_DIV4_MASK) == `ASP_PRE_DIV4_MASK;
            ASP_CLK_DIV12: tick = div12_hit(pre);
            ASP_CLK_DIV48: tick = (pre == `ASP_PRE_LAST);
            ASP_CLK_XOSC8: tick = ext_osc_clk && !xosc_prev && (xosc_cnt == `ASP_XOSC_LAST);
            ASP_CLK_EXT: tick = timer_ext_in && !ext_prev;
            default: tick = 1'b0;
        endcase
    end

    // ==========================================================
    // transmit counter: low byte in 8-bit auto-reload
    assign tx_ovf = run && tick && (tx_cnt == `ASP_CNT_TOP);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_cnt <= 8'h00;
            tx_half <= 1'b0;
        end else if (run && tick) begin
            tx_cnt <= (tx_cnt == `ASP_CNT_TOP) ? reload : tx_cnt + 8'h01;
            if (tx_ovf) begin
                tx_half <= !tx_half;
            end
        end
    end

    // every second overflow makes a bit
    assign tx_bit_tick = tx_ovf && tx_half;

    // ==========================================================
    // hidden receive copy, realigned by a start bit
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_cnt <= 8'h00;
        end else if (rx_restart) begin
            rx_cnt <= reload;
        end else if (run && tick) begin
            rx_cnt <= (rx_cnt == `ASP_CNT_TOP) ? reload : rx_cnt + 8'h01;
        end
    end

    assign rx_half_tick = run && tick && !rx_restart && (rx_cnt == `ASP_CNT_TOP);

    a_rx_restart_load: assert property (@(posedge pclk) disable iff (!presetn)
        rx_restart |=> rx_cnt == $past(reload))
        else $error("rx copy not reloaded on start bit");

    a_tx_reload_ovf: assert property (@(posedge pclk) disable iff (!presetn)
        tx_ovf |=> tx_cnt == $past(reload))
        else $error("tx counter did not auto-reload");

    a_tx_bit_half: assert property (@(posedge pclk) disable iff (!presetn)
        tx_ovf && !tx_half |=> !tx_bit_tick)
        else $error("bit tick not on every second overflow");

endmodule

// ==== rtl/asp_uart.sv ====
`timescale 1ns/1ps
`include "asp_defines.svh"

module asp_uart (
    input wire logic pclk, // system clock
    input wire logic presetn, // async reset, active low
    input wire logic psel, // apb select
    input wire logic penable, // apb enable
    input wire logic pwrite, // apb direction
    input wire logic [7:0] paddr, // apb byte address
    input wire logic [31:0] pwdata, // apb write data
    output logic [31:0] prdata, // apb read data
    output logic pready, // apb ready
    output logic pslverr, // apb error, unmapped address
    input wire logic rx_pin, // serial receive line
    output logic tx_pin, // serial transmit line
    input wire logic ext_osc_clk, // external oscillator
    input wire logic timer_ext_in, // external timer input
    output logic irq // level interrupt
);
    import asp_pkg::*;

    // ==========================================================
    // declarations
    logic mode9;
    logic mce;
    logic rx_en;
    logic tx_ninth_bit;
    logic rx_ninth_bit;
    logic tx_done_flag;
    logic rx_done_flag;
    logic [7:0] rx_buf;
    logic t_run;
    asp_clk_sel_t t_sel;
    logic [7:0] reload;
    logic [1:0] irq_stat;
    logic [1:0] irq_mask;
    logic [1:0] stat_clr;
    logic acc;
    logic wr_acc;
    logic tx_bit_tick;
    logic rx_half_tick;
    logic rx_restart;
    asp_tx_state_t tx_state;
    logic [8:0] tx_shift;
    logic [3:0] tx_cnt;
    logic [7:0] tx_hold;
    logic tx_pend;
    logic tx_m9;
    logic tx_n9_lat;
    logic tx_set;
    asp_rx_state_t rx_state;
    logic rx_meta;
    logic rx_s;
    logic rx_prev;
    logic rx_ph;
    logic [3:0] rx_cnt;
    logic [8:0] rx_shift;
    logic [7:0] rx_data;
    logic rx_chk;
    logic rx_load;

    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    function automatic logic mapped(input logic [7:0] a);
        mapped = hit(a, `ASP_OFF_CTRL) || hit(a, `ASP_OFF_DATA) ||
                 hit(a, `ASP_OFF_TCTRL) || hit(a, `ASP_OFF_RELOAD) ||
                 hit(a, `ASP_OFF_IRQ_STAT) || hit(a, `ASP_OFF_IRQ_MASK);
    endfunction

    // ==========================================================
    // apb slave
    // zero wait states; read data is captured in the setup cycle
    assign pready = 1'b1;
    assign acc = psel && penable;
    assign wr_acc = acc && pwrite && mapped(paddr);
    assign pslverr = acc && !mapped(paddr);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable) begin
            prdata <= 32'h00000000;
            if (!pwrite) begin
                case (paddr)
                    `ASP_OFF_CTRL: prdata[7:0] <= {mode9, 1'b1, mce, rx_en,
                        tx_ninth_bit, rx_ninth_bit, tx_done_flag, rx_done_flag};
                    `ASP_OFF_DATA: prdata[7:0] <= rx_buf;
                    `ASP_OFF_TCTRL: prdata[3:0] <= {t_sel, t_run};
                    `ASP_OFF_RELOAD: prdata[7:0] <= reload;
                    `ASP_OFF_IRQ_STAT: prdata[1:0] <= irq_stat;
                    `ASP_OFF_IRQ_MASK: prdata[1:0] <= irq_mask;
                    default: prdata <= 32'h00000000;
                endcase
            end
        end
    end

    // ==========================================================
    // control register; a hardware set beats a software clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode9 <= 1'b0;
            mce <= 1'b0;
            rx_en <= 1'b0;
            tx_ninth_bit <= 1'b0;
            rx_ninth_bit <= 1'b0;
            tx_done_flag <= 1'b0;
            rx_done_flag <= 1'b0;
        end else begin
            if (wr_acc && hit(paddr, `ASP_OFF_CTRL)) begin
                mode9 <= pwdata[`ASP_CTRL_MODE9];
                mce <= pwdata[`ASP_CTRL_MCE];
                rx_en <= pwdata[`ASP_CTRL_RXEN];
                tx_ninth_bit <= pwdata[`ASP_CTRL_TXN9];
                rx_ninth_bit <= pwdata[`ASP_CTRL_RXN9];
                tx_done_flag <= pwdata[`ASP_CTRL_TXDONE];
                rx_done_flag <= pwdata[`ASP_CTRL_RXDONE];
            end
            if (tx_set) begin
                tx_done_flag <= 1'b1;
            end
            if (rx_load) begin
                rx_done_flag <= 1'b1;
                rx_ninth_bit <= rx_chk;
            end
        end
    end

    // baud timer configuration
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            t_run <= 1'b0;
            t_sel <= ASP_CLK_SYS;
            reload <= 8'h00;
        end else if (wr_acc) begin
            if (hit(paddr, `ASP_OFF_TCTRL)) begin
                t_run <= pwdata[`ASP_TCTRL_RUN];
                t_sel <= asp_clk_sel_t'(pwdata[`ASP_TCTRL_SEL_MSB:`ASP_TCTRL_SEL_LSB]);
            end
            if (hit(paddr, `ASP_OFF_RELOAD)) begin
                reload <= pwdata[7:0];
            end
        end
    end

    // ==========================================================
    // interrupts: read clears only the bits that the read returned
    assign stat_clr = (acc && !pwrite && hit(paddr, `ASP_OFF_IRQ_STAT)) ? prdata[1:0] : 2'h0;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            irq_stat <= 2'h0;
            irq_mask <= 2'h0;
        end else begin
            irq_stat <= (irq_stat & ~stat_clr) | {rx_load, tx_set};
            if (wr_acc && hit(paddr, `ASP_OFF_IRQ_MASK)) begin
                irq_mask <= pwdata[1:0];
            end
        end
    end

    assign irq = |(irq_stat & irq_mask);

    // ==========================================================
    // baud generation
    asp_baud_timer u_timer (
        .pclk(pclk),
        .presetn(presetn),
        .run(t_run),
        .sel(t_sel),
        .reload(reload),
        .ext_osc_clk(ext_osc_clk),
        .timer_ext_in(timer_ext_in),
        .rx_restart(rx_restart),
        .tx_bit_tick(tx_bit_tick),
        .rx_half_tick(rx_half_tick)
    );

    // ==========================================================
    // transmitter; a frame starts on the first bit tick in TX_IDLE after a write
    assign tx_set = tx_bit_tick && (((tx_state == TX_DATA) && (tx_cnt == `ASP_BITS_8) && !tx_m9) ||
                    (tx_state == TX_NINTH));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            tx_state <= TX_IDLE;
            tx_pin <= 1'b1;
            tx_shift <= 9'h000;
            tx_cnt <= 4'h0;
            tx_hold <= 8'h00;
            tx_pend <= 1'b0;
            tx_m9 <= 1'b0;
            tx_n9_lat <= 1'b0;
        end else begin
            if (tx_bit_tick) begin
                case (tx_state)
                    TX_IDLE: begin
                        if (tx_pend) begin
                            tx_pin <= 1'b0;
                            tx_shift <= {tx_ninth_bit, tx_hold};
                            tx_n9_lat <= tx_ninth_bit;
                            tx_m9 <= mode9;
                            tx_pend <= 1'b0;
                            tx_state <= TX_START;
                        end
                    end
                    TX_START: begin
                        tx_pin <= tx_shift[0];
                        tx_shift <= {1'b0, tx_shift[8:1]};
                        tx_cnt <= 4'h0;
                        tx_state <= TX_DATA;
                    end
                    TX_DATA: begin
                        if (tx_cnt == `ASP_BITS_8) begin
                            tx_pin <= tx_m9 ? tx_shift[0] : 1'b1;
                            tx_state <= tx_m9 ? TX_NINTH : TX_STOP;
                        end else begin
                            tx_pin <= tx_shift[0];
                            tx_shift <= {1'b0, tx_shift[8:1]};
                            tx_cnt <= tx_cnt + 4'h1;
                        end
                    end
                    TX_NINTH: begin
                        tx_pin <= 1'b1;
                        tx_state <= TX_STOP;
                    end
                    TX_STOP: begin
                        tx_state <= TX_IDLE;
                    end
                    default: begin
                        tx_pin <= 1'b1;
                        tx_state <= TX_IDLE;
                    end
                endcase
            end
            // a write lands only in the transmit register
            if (wr_acc && hit(paddr, `ASP_OFF_DATA)) begin
                tx_hold <= pwdata[7:0];
                tx_pend <= 1'b1;
            end
        end
    end

    // ==========================================================
    // receive pin synchroniser and edge history
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_meta <= 1'b1;
            rx_s <= 1'b1;
            rx_prev <= 1'b1;
        end else begin
            rx_meta <= rx_pin;
            rx_s <= rx_meta;
            rx_prev <= rx_s;
        end
    end

    assign rx_restart = (rx_state == RX_IDLE) && rx_en && rx_prev && !rx_s;
    assign rx_data = mode9 ? rx_shift[7:0] : rx_shift[8:1];
    assign rx_chk = mode9 ? rx_shift[8] : rx_s;
    assign rx_load = (rx_state == RX_STOP) && rx_half_tick && rx_ph && !rx_done_flag &&
                     (!mce || rx_chk);

    // ==========================================================
    // receiver; half-bit overflows are halved by rx_ph so that
    // each bit is sampled one half bit after its edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_state <= RX_IDLE;
            rx_ph <= 1'b0;
            rx_cnt <= 4'h0;
            rx_shift <= 9'h000;
        end else begin
            case (rx_state)
                RX_IDLE: begin
                    if (rx_restart) begin
                        rx_state <= RX_START;
                    end
                end
                RX_START: begin
                    // glitch rejection: start must still be low at centre
                    if (rx_half_tick) begin
                        rx_state <= rx_s ? RX_IDLE : RX_DATA;
                        rx_ph <= 1'b0;
                        rx_cnt <= 4'h0;
                    end
                end
                RX_DATA: begin
                    if (rx_half_tick) begin
                        rx_ph <= !rx_ph;
                        if (rx_ph) begin
                            rx_shift <= {rx_s, rx_shift[8:1]};
                            rx_cnt <= rx_cnt + 4'h1;
                            if (rx_cnt == (mode9 ? `ASP_BITS_9 : `ASP_BITS_8)) begin
                                rx_state <= RX_STOP;
                            end
                        end
                    end
                end
                RX_STOP: begin
                    if (rx_half_tick) begin
                        rx_ph <= !rx_ph;
                        if (rx_ph) begin
                            rx_state <= RX_IDLE;
                        end
                    end
                end
                default: begin
                    rx_state <= RX_IDLE;
                end
            endcase
        end
    end

    // holding buffer lets the shifter take the next frame at once
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            rx_buf <= 8'h00;
        end else if (rx_load) begin
            rx_buf <= rx_data;
        end
    end

    // ==========================================================
    // checks
    a_tx_done_stop: assert property (@(posedge pclk) disable iff (!presetn)
        tx_set |=> tx_pin && (tx_state == TX_STOP))
        else $error("tx done not at start of stop bit");

    a_flag_sticky: assert property (@(posedge pclk) disable iff (!presetn)
        rx_done_flag && !(wr_acc && hit(paddr, `ASP_OFF_CTRL)) |=> rx_done_flag)
        else $error("rx done flag cleared by hardware");

    // a software write of 1 may also raise the flag, so only hardware loads are judged
    a_rx_load_cond: assert property (@(posedge pclk) disable iff (!presetn)
        $rose(rx_done_flag) && !$past(wr_acc && (paddr == `ASP_OFF_CTRL)) |->
        $past(!rx_done_flag && (!mce || rx_chk)))
        else $error("byte stored with flag set or check bit low");

    a_write_no_rx: assert property (@(posedge pclk) disable iff (!presetn)
        wr_acc && hit(paddr, `ASP_OFF_DATA) && !rx_load |=> $stable(rx_buf))
        else $error("data write disturbed receive buffer");

    a_read_rx_buf: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && !pwrite && hit(paddr, `ASP_OFF_DATA) |=> prdata[7:0] == $past(rx_buf))
        else $error("data read did not return receive buffer");

    a_irq_on_flag: assert property (@(posedge pclk) disable iff (!presetn)
        tx_set && irq_mask[`ASP_IRQ_TX] && !(wr_acc && hit(paddr, `ASP_OFF_IRQ_MASK)) |=> irq)
        else $error("no interrupt after tx done");

    a_ninth_bit_out: assert property (@(posedge pclk) disable iff (!presetn)
        tx_state == TX_NINTH |-> tx_pin == tx_n9_lat)
        else $error("ninth bit differs from control bit");

    a_start_center: assert property (@(posedge pclk) disable iff (!presetn)
        rx_state == RX_START && rx_half_tick && !rx_s |=> rx_state == RX_DATA && !rx_ph)
        else $error("valid start bit not accepted at centre");

endmodule

// ==== tb/asp_line_model.sv ====
`timescale 1ns/1ps
// ==========================================
// remote serial port on the line side
module asp_line_model (
    input wire logic pclk, // system clock
    input wire logic tx_pin, // line from the device
    input wire logic nine, // expect a ninth bit
    output logic rx_pin // line into the device, idle high
);
    localparam int BIT = 8; // clocks per bit with reload FC
    logic [8:0] got = '0; // last frame decoded
    int low_run = 0;
    int last_low = 0;
    int i;
    initial rx_pin = 1'b1;
    // length of the latest low run, which gives the bit time
    always @(posedge pclk) begin
        low_run <= tx_pin ? 0 : low_run + 1;
        if (tx_pin && low_run != 0) last_low <= low_run;
    end
    // sample each bit at its centre, lsb first
    always begin
        @(posedge pclk);
        if (tx_pin === 1'b0) begin
            repeat (BIT / 2) @(posedge pclk);
            for (i = 0; i < (nine ? 9 : 8); i++) begin
                repeat (BIT) @(posedge pclk);
                got[i] = tx_pin;
            end
            repeat (BIT) @(posedge pclk); // ride out the stop bit
        end
    end
    // start, data lsb first, optional ninth, stop; line left high after
    task automatic send(input logic [7:0] d, input logic ninth, input logic with9);
        logic [10:0] fr;
        int k;
        fr = {1'b1, ninth, d, 1'b0};
        for (k = 0; k < (with9 ? 11 : 10); k++) begin
            rx_pin <= (k == 9 && !with9) ? 1'b1 : fr[k];
            repeat (BIT) @(posedge pclk);
        end
    endtask
endmodule

// ==== tb/async_serial_port_baud_gen_tb_top.sv ====
`timescale 1ns/1ps
`include "asp_defines.svh"

module async_serial_port_baud_gen_tb_top;
    logic pclk = 1'b0;
    logic t_ext = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, tx_pin, rx_pin, irq, nine, err_seen;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, q;
    int err_total = 0;
    int comparisons = 0;
    int cyc = 0;

    always #12.5 pclk = ~pclk;
    // external timer input: one rising edge every second clock
    always @(posedge pclk) t_ext <= ~t_ext;

    asp_uart i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .rx_pin(rx_pin), .tx_pin(tx_pin), .ext_osc_clk(1'b0), .timer_ext_in(t_ext), .irq(irq));
    asp_line_model u_line (.pclk(pclk), .tx_pin(tx_pin), .nine(nine), .rx_pin(rx_pin));

    // ==========================================
    // helpers
    task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            err_total++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    // one apb transfer, held until pready; an idle clock keeps drives apart
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err_seen = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic rdchk(input string name, input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(name, q, exp);
    endtask
    // poll a control flag under a bounded count
    task automatic wait_flag(input int b);
        int n;
        n = 0;
        do begin
            apb(1'b0, `ASP_OFF_CTRL, 32'h0);
            n++;
        end while (q[b] !== 1'b1 && n < 300);
        chk("flag", q[b], 1'b1);
    endtask
    task automatic end_of_test();
        $display("comparisons %0d err_total %0d", comparisons, err_total);
        if (err_total == 0 && comparisons > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // cut a hang short, far above the 1400 or so clocks expected
    always @(posedge pclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            err_total++;
            end_of_test();
        end
    end

    // ==========================================
    // main sequence
    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        nine = 1'b0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rdchk("ctrl", `ASP_OFF_CTRL, 32'h40);
        chk("irq", irq, 1'b0);
        // bit time 2*(256-FC) = 8 clocks of the system clock
        apb(1'b1, `ASP_OFF_RELOAD, 32'hFC);
        apb(1'b1, `ASP_OFF_TCTRL, 32'h1);
        apb(1'b1, `ASP_OFF_IRQ_MASK, 32'h3);
        apb(1'b1, `ASP_OFF_CTRL, 32'h10);
        apb(1'b1, `ASP_OFF_DATA, 32'hA5);
        wait_flag(1);
        repeat (16) @(posedge pclk);
        chk("tx_byte", u_line.got[7:0], 8'hA5);
        chk("bit_time", u_line.last_low, 8);
        chk("irq", irq, 1'b1);
        rdchk("ctrl", `ASP_OFF_CTRL, 32'h52);
        rdchk("stat", `ASP_OFF_IRQ_STAT, 32'h1);
        rdchk("stat", `ASP_OFF_IRQ_STAT, 32'h0);
        chk("irq", irq, 1'b0);
        rdchk("data", `ASP_OFF_DATA, 32'h0);
        apb(1'b1, `ASP_OFF_CTRL, 32'h10);
        // receive at a phase unrelated to the transmit timer
        u_line.send(8'h3C, 1'b0, 1'b0);
        wait_flag(0);
        rdchk("data", `ASP_OFF_DATA, 32'h3C);
        rdchk("ctrl", `ASP_OFF_CTRL, 32'h55);
        rdchk("stat", `ASP_OFF_IRQ_STAT, 32'h2);
        // flag still set, so the next byte is dropped
        u_line.send(8'h5A, 1'b0, 1'b0);
        repeat (20) @(posedge pclk);
        rdchk("data", `ASP_OFF_DATA, 32'h3C);
        // nine-bit framing with the address check on
        apb(1'b1, `ASP_OFF_CTRL, 32'hB0);
        u_line.send(8'h11, 1'b0, 1'b1);
        repeat (20) @(posedge pclk);
        rdchk("ctrl", `ASP_OFF_CTRL, 32'hF0);
        u_line.send(8'h22, 1'b1, 1'b1);
        wait_flag(0);
        rdchk("data", `ASP_OFF_DATA, 32'h22);
        rdchk("ctrl", `ASP_OFF_CTRL, 32'hF5);
        nine <= 1'b1;
        apb(1'b1, `ASP_OFF_CTRL, 32'hB8);
        apb(1'b1, `ASP_OFF_DATA, 32'h81);
        wait_flag(1);
        repeat (16) @(posedge pclk);
        chk("tx_frame", u_line.got, 9'h181);
        // slower timer clocks: /4 gives 32 clocks a bit, the external edge input 16
        apb(1'b1, `ASP_OFF_CTRL, 32'h10);
        apb(1'b1, `ASP_OFF_TCTRL, 32'h3);
        apb(1'b1, `ASP_OFF_DATA, 32'h55);
        wait_flag(1);
        repeat (8) @(posedge pclk);
        chk("bit_div4", u_line.last_low, 32);
        apb(1'b1, `ASP_OFF_CTRL, 32'h10);
        apb(1'b1, `ASP_OFF_TCTRL, 32'hB);
        apb(1'b1, `ASP_OFF_DATA, 32'h55);
        wait_flag(1);
        repeat (8) @(posedge pclk);
        chk("bit_ext", u_line.last_low, 16);
        rdchk("unmapped", 8'h18, 32'h0);
        chk("pslverr", err_seen, 1'b1);
        end_of_test();
    end
endmodule
